// >>> rtl/rtc_pkg.sv
// Constants for the reload timer with clock output.
// Assumes a 32-bit AHB-Lite register bus and a 100 MHz system clock.
package rtc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_MODE = 8'hCC;
  localparam logic [7:0] ADDR_COUNT = 8'hD0;
  localparam logic [7:0] ADDR_RELOAD = 8'hD4;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 7;

  // Control register bit positions
  localparam int CTL_OVF = 7;
  localparam int CTL_EXT = 6;
  localparam int CTL_RCLK = 5;
  localparam int CTL_TX_CLOCK_SELECT = 4;
  localparam int CTL_EXEN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CSEL = 1;
  localparam int CTL_CPRL = 0;

  // Mode register bit positions
  localparam int MOD_OE = 1;
  localparam int MOD_UPDOWN_ENABLE = 0;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic PIN_IDLE = 1'b1;

  // Counting figures
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam int TIMER_DIV = 6;
  localparam logic [2:0] PRESC_LAST = 3'(TIMER_DIV - 1);
  localparam logic [2:0] PRESC_ZERO = 3'h0;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : rtc_pkg

// >>> rtl/rtc_pin_sync.sv
// Three-stage synchroniser for one pin, with a filtered level and a
// falling-edge pulse.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/1ns
`default_nettype none
module rtc_pin_sync (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Pin side
  input wire logic pin_i,
  // Synchronised side
  output logic level_o,
  output logic fall_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic fall_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s1_q <= rtc_pkg::PIN_IDLE;
      s2_q <= rtc_pkg::PIN_IDLE;
      s3_q <= rtc_pkg::PIN_IDLE;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once the second and third stage agree
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      level_q <= rtc_pkg::PIN_IDLE;
      fall_q <= 1'b0;
    end else begin
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
      fall_q <= level_q && (s2_q == s3_q) && !s3_q;
    end
  end

  assign level_o = level_q;
  assign fall_o = fall_q;
endmodule : rtc_pin_sync
`default_nettype wire

// >>> rtl/rtc_timer.sv
// Reload timer/counter with up/down counting and a clock output,
// reached over an AHB-Lite slave port.
// Assumes single word transfers, one clock, synchronous reset.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module rtc_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Clock pin, three-signal form
  input wire logic clock_io_i,
  output logic clock_io_o,
  output logic clock_io_oe_o,
  // Direction and external event pin
  input wire logic direction_ext_i,
  // Serial port clocks and interrupt request
  output logic rx_clock_o,
  output logic tx_clock_o,
  output logic timer_irq_o
);
  logic [7:0] ctrl_q;
  logic [1:0] mode_q;
  logic [7:0] count_high_q;
  logic [7:0] count_low_q;
  logic [15:0] reload_q;
  logic [2:0] presc_q;
  logic wave_q;
  logic [31:0] rdata_q;
  logic dph_wr_q;
  logic [7:0] dph_addr_q;

  logic clk_pin_level;
  logic clk_pin_fall;
  logic dir_level;
  logic dir_fall;

  logic overflow_flag;
  logic external_flag;
  logic rx_clock_select;
  logic tx_clock_select;
  logic ext_enable;
  logic run_control;
  logic counter_select;
  logic clock_out_enable;
  logic updown_enable;

  logic [15:0] count;
  logic baud_mode;
  logic fast_rate;
  logic updown_mode;
  logic count_up;
  logic int_tick;
  logic tick;
  logic roll_up;
  logic roll_dn;
  logic roll;
  logic ext_evt;
  logic flag_set;
  logic addr_ph;
  logic ctl_wr;
  logic mod_wr;
  logic cnt_wr;
  logic rld_wr;
  logic [15:0] count_d;

  rtc_pin_sync u_clk_pin (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(clock_io_i),
    .level_o(clk_pin_level),
    .fall_o(clk_pin_fall)
  );

  rtc_pin_sync u_dir_pin (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(direction_ext_i),
    .level_o(dir_level),
    .fall_o(dir_fall)
  );

  assign overflow_flag = ctrl_q[rtc_pkg::CTL_OVF];
  assign external_flag = ctrl_q[rtc_pkg::CTL_EXT];
  assign rx_clock_select = ctrl_q[rtc_pkg::CTL_RCLK];
  assign tx_clock_select = ctrl_q[rtc_pkg::CTL_TX_CLOCK_SELECT];
  assign ext_enable = ctrl_q[rtc_pkg::CTL_EXEN];
  assign run_control = ctrl_q[rtc_pkg::CTL_RUN];
  assign counter_select = ctrl_q[rtc_pkg::CTL_CSEL];
  assign clock_out_enable = mode_q[rtc_pkg::MOD_OE];
  assign updown_enable = mode_q[rtc_pkg::MOD_UPDOWN_ENABLE];
  assign count = {count_high_q, count_low_q};

  // Bus decode: zero wait states, always OKAY
  assign addr_ph = hsel_i && hready_i && (htrans_i == rtc_pkg::HTRANS_NONSEQ);
  assign ctl_wr = dph_wr_q && (dph_addr_q == rtc_pkg::ADDR_CTRL);
  assign mod_wr = dph_wr_q && (dph_addr_q == rtc_pkg::ADDR_MODE);
  assign cnt_wr = dph_wr_q && (dph_addr_q == rtc_pkg::ADDR_COUNT);
  assign rld_wr = dph_wr_q && (dph_addr_q == rtc_pkg::ADDR_RELOAD);
  assign hreadyout_o = 1'b1;
  assign hresp_o = rtc_pkg::HRESP_OKAY;
  assign hrdata_o = rdata_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dph_wr_q <= 1'b0;
      dph_addr_q <= 8'h00;
    end else begin
      dph_wr_q <= addr_ph && hwrite_i;
      dph_addr_q <= {haddr_i[rtc_pkg::ADDR_MSB:rtc_pkg::ADDR_LSB], 2'h0};
    end
  end

  // Read data is snapshot at the address phase; unmapped reads give zero
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ph && !hwrite_i) begin
      unique case ({haddr_i[rtc_pkg::ADDR_MSB:rtc_pkg::ADDR_LSB], 2'h0})
        rtc_pkg::ADDR_CTRL: rdata_q <= {24'h000000, ctrl_q};
        rtc_pkg::ADDR_MODE: rdata_q <= {30'h0000_0000, mode_q};
        rtc_pkg::ADDR_COUNT: rdata_q <= {16'h0000, count};
        rtc_pkg::ADDR_RELOAD: rdata_q <= {16'h0000, reload_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Clock-out, and serial clocking with counter_select clear, run at half clock off one reload
  assign baud_mode = rx_clock_select || tx_clock_select;
  assign fast_rate = clock_out_enable || baud_mode;
  assign updown_mode = updown_enable && !fast_rate;
  assign count_up = !updown_mode || dir_level;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      presc_q <= rtc_pkg::PRESC_ZERO;
    end else if (presc_q == rtc_pkg::PRESC_LAST) begin
      presc_q <= rtc_pkg::PRESC_ZERO;
    end else begin
      presc_q <= presc_q + 3'h1;
    end
  end

  // Odd prescaler states give a tick every second cycle; six is odd-free
  // of jitter because the wrap goes from odd state 5 to even state 0.
  assign int_tick = fast_rate ? presc_q[0] : (presc_q == rtc_pkg::PRESC_LAST);
  assign tick = run_control &&
                ((counter_select && !clock_out_enable) ? clk_pin_fall : int_tick);

  assign roll_up = tick && count_up && (count == rtc_pkg::COUNT_MAX);
  assign roll_dn = tick && !count_up && (count == reload_q);
  assign roll = roll_up || roll_dn;
  // The direction pin only acts as an event pin outside up/down mode
  assign ext_evt = ext_enable && dir_fall && !baud_mode && !updown_mode;
  assign flag_set = roll && !baud_mode && !clock_out_enable;

  always_comb begin
    count_d = count;
    if (ext_evt) begin
      count_d = reload_q;
    end else if (roll_up) begin
      count_d = reload_q;
    end else if (roll_dn) begin
      count_d = rtc_pkg::COUNT_MAX;
    end else if (tick && count_up) begin
      count_d = count + 16'h0001;
    end else if (tick) begin
      count_d = count - 16'h0001;
    end
  end

  // A software write to the count wins over a tick in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      count_high_q <= rtc_pkg::COUNT_RST[15:8];
      count_low_q <= rtc_pkg::COUNT_RST[7:0];
    end else if (cnt_wr) begin
      count_high_q <= hwdata_i[15:8];
      count_low_q <= hwdata_i[7:0];
    end else begin
      count_high_q <= count_d[15:8];
      count_low_q <= count_d[7:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      reload_q <= rtc_pkg::RELOAD_RST;
    end else if (rld_wr) begin
      reload_q <= hwdata_i[15:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_q <= rtc_pkg::MODE_RST;
    end else if (mod_wr) begin
      mode_q <= hwdata_i[1:0];
    end
  end

  // Plain control bits follow software writes
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q[5:0] <= rtc_pkg::CTRL_RST[5:0];
    end else if (ctl_wr) begin
      ctrl_q[5:0] <= hwdata_i[5:0];
    end
  end

  // Overflow flag: hardware set wins over a clearing write
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q[rtc_pkg::CTL_OVF] <= rtc_pkg::CTRL_RST[rtc_pkg::CTL_OVF];
    end else if (flag_set) begin
      ctrl_q[rtc_pkg::CTL_OVF] <= 1'b1;
    end else if (ctl_wr) begin
      ctrl_q[rtc_pkg::CTL_OVF] <= hwdata_i[rtc_pkg::CTL_OVF];
    end
  end

  // External flag: toggles as a seventeenth bit in up/down mode
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q[rtc_pkg::CTL_EXT] <= rtc_pkg::CTRL_RST[rtc_pkg::CTL_EXT];
    end else if (updown_mode && roll) begin
      ctrl_q[rtc_pkg::CTL_EXT] <= !external_flag;
    end else if (ext_evt) begin
      ctrl_q[rtc_pkg::CTL_EXT] <= 1'b1;
    end else if (ctl_wr) begin
      ctrl_q[rtc_pkg::CTL_EXT] <= hwdata_i[rtc_pkg::CTL_EXT];
    end
  end

  // Toggling once per overflow halves the roll rate: F / (4 * (65536 - R))
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wave_q <= 1'b0;
    end else if (clock_out_enable && roll) begin
      wave_q <= !wave_q;
    end
  end

  assign clock_io_o = wave_q;
  assign clock_io_oe_o = clock_out_enable;
  assign rx_clock_o = roll && rx_clock_select;
  assign tx_clock_o = roll && tx_clock_select;
  // In up/down mode the external flag is only a count bit
  assign timer_irq_o = overflow_flag || (external_flag && !updown_mode);

  // Checks
  sequence s_up_wrap;
    tick && count_up && (count == rtc_pkg::COUNT_MAX) && !cnt_wr && !ext_evt;
  endsequence

  sequence s_dn_wrap;
    tick && !count_up && (count == reload_q) && !cnt_wr && !ext_evt;
  endsequence

  a_byte_carry: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (tick && count_up && count_low_q == rtc_pkg::BYTE_MAX && !roll && !cnt_wr && !ext_evt)
    |=> count_high_q == $past(count_high_q) + 8'h01 && count_low_q == 8'h00)
    else $error("High byte did not take the low byte carry");

  a_timer_div_six: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i || ctl_wr || mod_wr)
    (tick && !counter_select && !fast_rate) |=> !tick [*5] ##1 tick)
    else $error("Timer operation tick spacing is not six cycles");

  a_stopped_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (!run_control && !cnt_wr && !ext_evt) |=> $stable(count))
    else $error("Count moved while stopped");

  a_up_overflow: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i || rld_wr)
    (s_up_wrap and (!baud_mode && !clock_out_enable))
    |=> overflow_flag && timer_irq_o && count == $past(reload_q))
    else $error("Up overflow did not reload or flag");

  a_down_underflow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    s_dn_wrap |=> count == rtc_pkg::COUNT_MAX && overflow_flag)
    else $error("Underflow did not load all ones or flag");

  a_ext_toggle: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i || ctl_wr)
    (updown_mode && roll) |=> external_flag != $past(external_flag))
    else $error("External flag did not toggle on roll");

  a_half_rate: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i || ctl_wr || mod_wr)
    (tick && clock_out_enable) |=> !tick ##1 tick)
    else $error("Clock-out tick is not every second cycle");

  a_clkout_quiet: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i || ctl_wr)
    (clock_out_enable && roll) |=> overflow_flag == $past(overflow_flag))
    else $error("Clock-out overflow touched the overflow flag");

  a_wave_pin: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (clock_out_enable && roll) |=> clock_io_o != $past(clock_io_o) && clock_io_oe_o)
    else $error("Clock pin did not toggle on overflow");

  a_baud_no_flag: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i || ctl_wr)
    (baud_mode && !overflow_flag) |=> !overflow_flag)
    else $error("Overflow flag set while clocking the serial port");

  a_ext_reload: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i || cnt_wr || rld_wr)
    ext_evt |=> external_flag && timer_irq_o && count == $past(reload_q))
    else $error("External event did not reload and flag");

  a_serial_route: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (rx_clock_o || tx_clock_o) |-> roll && baud_mode)
    else $error("Serial clock pulse without a timer roll");
endmodule : rtc_timer
`default_nettype wire

// >>> verif/tb_reload_timer_clock_out.sv
// Self-checking bench for the reload timer with clock output.
// Assumes the timer answers the register bus with zero wait states.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb_reload_timer_clock_out;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic clock_io_i = 1'b1;
  logic direction_ext_i = 1'b1;
  logic hreadyout_o, hresp_o, clock_io_o, clock_io_oe_o, rx_clock_o, tx_clock_o, timer_irq_o;
  logic [31:0] hrdata_o;
  logic [31:0] rd;
  logic [15:0] r;
  logic seen_tx;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  int t;
  int m;

  rtc_timer uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o), .clock_io_i(clock_io_i),
    .clock_io_o(clock_io_o), .clock_io_oe_o(clock_io_oe_o),
    .direction_ext_i(direction_ext_i), .rx_clock_o(rx_clock_o), .tx_clock_o(tx_clock_o),
    .timer_irq_o(timer_irq_o));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, well above the fewer than one thousand cycles the tests need
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("[ERR] cycle_limit exp %0d got %0d", 19999, cyc);
      end_of_test();
    end
  end

  // One single word transfer; read data is taken at the edge ending the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    htrans_i <= rtc_pkg::HTRANS_NONSEQ;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    rd = hrdata_o;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    `CHK(nm, exp, rd)
  endtask : rdchk

  function automatic logic sig(input int s);
    case (s)
      0: return clock_io_o;
      1: return timer_irq_o;
      default: return rx_clock_o;
    endcase
  endfunction : sig

  // Reference model of one count step, written from the reload rules
  function automatic int mdl_step(input int c, input int rl, input bit up);
    if (up) begin
      return (c == 32'h0000_FFFF) ? rl : c + 32'h1;
    end
    return (c == rl) ? 32'h0000_FFFF : c - 32'h1;
  endfunction : mdl_step

  // Sampling at the falling edge keeps one-cycle combinational pulses visible
  task automatic wait_lvl(input int s, input logic lv);
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (sig(s) !== lv && n < 2000);
    if (n >= 2000) begin
      bad_count++;
      $display("[ERR] wait_limit exp %0d got %0d", lv, sig(s));
    end
    seen_tx = tx_clock_o;
    @(posedge sys_clk_i);
  endtask : wait_lvl

  // Pin pulses are long enough to pass the three-stage synchroniser
  task automatic pin_fall(input int k);
    repeat (k) begin
      clock_io_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      clock_io_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask : pin_fall

  task automatic dir_set(input logic v);
    direction_ext_i <= v;
    repeat (12) @(posedge sys_clk_i);
  endtask : dir_set

  initial begin
    void'($urandom(32'hC0177BB0));
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rdchk("ctrl_rst", rtc_pkg::ADDR_CTRL, 32'h0);
    rdchk("mode_rst", rtc_pkg::ADDR_MODE, 32'h0);
    rdchk("count_rst", rtc_pkg::ADDR_COUNT, 32'h0);
    wr(8'hE0, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'hE0, 32'h0);
    wr(rtc_pkg::ADDR_MODE, 32'hFFFF_FFFF);
    rdchk("mode_rsv", rtc_pkg::ADDR_MODE, 32'h3);
    wr(rtc_pkg::ADDR_MODE, 32'h0);
    `CHK("resp", 1'b0, hresp_o)
    `CHK("ready", 1'b1, hreadyout_o)
    $display("test registers done");

    wr(rtc_pkg::ADDR_COUNT, 32'h1234);
    pin_fall(3);
    repeat (30) @(posedge sys_clk_i);
    rdchk("count_hold", rtc_pkg::ADDR_COUNT, 32'h1234);
    wr(rtc_pkg::ADDR_COUNT, 32'h00FD);
    wr(rtc_pkg::ADDR_CTRL, 32'h06);
    pin_fall(5);
    m = 32'h0000_00FD;
    repeat (5) m = mdl_step(m, 32'h0, 1'b1);
    rdchk("count_pin", rtc_pkg::ADDR_COUNT, m);
    wr(rtc_pkg::ADDR_CTRL, 32'h0);
    $display("test counter done");

    r = 16'hFFE0 + 16'($urandom % 16);
    wr(rtc_pkg::ADDR_RELOAD, {16'h0, r});
    wr(rtc_pkg::ADDR_COUNT, 32'hFFFF);
    wr(rtc_pkg::ADDR_CTRL, 32'h04);
    wait_lvl(1, 1'b1);
    wr(rtc_pkg::ADDR_CTRL, 32'h04);
    wait_lvl(1, 1'b1);
    // Counting starts three edges after the first roll, at the clearing write
    t = 6 * (65536 - int'(r)) - 2;
    `CHK("timer_period", t, n)
    wr(rtc_pkg::ADDR_CTRL, 32'h0);
    $display("test timer done");

    wr(rtc_pkg::ADDR_MODE, 32'h1);
    dir_set(1'b0);
    wr(rtc_pkg::ADDR_COUNT, {16'h0, r + 16'h3});
    wr(rtc_pkg::ADDR_CTRL, 32'h06);
    pin_fall(4);
    m = int'(r) + 32'h3;
    repeat (4) m = mdl_step(m, int'(r), 1'b0);
    rdchk("down_count", rtc_pkg::ADDR_COUNT, m);
    rdchk("down_ctrl", rtc_pkg::ADDR_CTRL, 32'hC6);
    wr(rtc_pkg::ADDR_CTRL, 32'h46);
    repeat (2) @(posedge sys_clk_i);
    `CHK("ext_noirq", 1'b0, timer_irq_o)
    dir_set(1'b1);
    pin_fall(1);
    m = mdl_step(m, int'(r), 1'b1);
    rdchk("up_count", rtc_pkg::ADDR_COUNT, m);
    rdchk("up_ctrl", rtc_pkg::ADDR_CTRL, 32'h86);
    `CHK("up_irq", 1'b1, timer_irq_o)
    wr(rtc_pkg::ADDR_CTRL, 32'h0);
    wr(rtc_pkg::ADDR_MODE, 32'h0);
    $display("test updown done");

    wr(rtc_pkg::ADDR_MODE, 32'h2);
    wr(rtc_pkg::ADDR_CTRL, 32'h0);
    wr(rtc_pkg::ADDR_RELOAD, {16'h0, r});
    wr(rtc_pkg::ADDR_COUNT, {16'h0, r});
    wr(rtc_pkg::ADDR_CTRL, 32'h04);
    `CHK("oe_on", 1'b1, clock_io_oe_o)
    t = 2 * (65536 - int'(r));
    wait_lvl(0, !clock_io_o);
    wait_lvl(0, !clock_io_o);
    `CHK("clk_high", t, n)
    wait_lvl(0, !clock_io_o);
    `CHK("clk_low", t, n)
    `CHK("clk_noirq", 1'b0, timer_irq_o)
    rdchk("clk_ctrl", rtc_pkg::ADDR_CTRL, 32'h04);
    wr(rtc_pkg::ADDR_CTRL, 32'h0);
    wr(rtc_pkg::ADDR_MODE, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    `CHK("oe_off", 1'b0, clock_io_oe_o)
    $display("test clockout done");

    wr(rtc_pkg::ADDR_COUNT, 32'hFFFF);
    wr(rtc_pkg::ADDR_MODE, 32'h2);
    wr(rtc_pkg::ADDR_CTRL, 32'h34);
    wait_lvl(2, 1'b1);
    wait_lvl(2, 1'b0);
    t = n;
    wait_lvl(2, 1'b1);
    `CHK("serial_period", 2 * (65536 - int'(r)), t + n)
    `CHK("serial_tx", 1'b1, seen_tx)
    rdchk("serial_ctrl", rtc_pkg::ADDR_CTRL, 32'h34);
    `CHK("serial_oe", 1'b1, clock_io_oe_o)
    wr(rtc_pkg::ADDR_CTRL, 32'h0);
    wr(rtc_pkg::ADDR_MODE, 32'h0);
    $display("test serial done");

    wr(rtc_pkg::ADDR_COUNT, 32'h1234);
    wr(rtc_pkg::ADDR_CTRL, 32'h08);
    dir_set(1'b0);
    rdchk("evt_count", rtc_pkg::ADDR_COUNT, {16'h0, r});
    rdchk("evt_ctrl", rtc_pkg::ADDR_CTRL, 32'h48);
    `CHK("evt_irq", 1'b1, timer_irq_o)
    dir_set(1'b1);
    wr(rtc_pkg::ADDR_CTRL, 32'h0);
    wr(rtc_pkg::ADDR_COUNT, 32'h1234);
    dir_set(1'b0);
    rdchk("noevt_count", rtc_pkg::ADDR_COUNT, 32'h1234);
    rdchk("noevt_ctrl", rtc_pkg::ADDR_CTRL, 32'h0);
    $display("test event done");

    // Reset in mid-run with clock-out active; pin high so no false edge follows
    dir_set(1'b1);
    wr(rtc_pkg::ADDR_MODE, 32'h2);
    wr(rtc_pkg::ADDR_CTRL, 32'h04);
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    `CHK("oe_rst", 1'b0, clock_io_oe_o)
    `CHK("wave_rst", 1'b0, clock_io_o)
    `CHK("irq_rst", 1'b0, timer_irq_o)
    rdchk("mode_rst2", rtc_pkg::ADDR_MODE, 32'h0);
    rdchk("count_rst2", rtc_pkg::ADDR_COUNT, 32'h0);
    rdchk("ctrl_rst2", rtc_pkg::ADDR_CTRL, 32'h0);
    $display("test reset done");
    end_of_test();
  end
endmodule : tb_reload_timer_clock_out
`default_nettype wire
